// File: hdl/updown_counter_pkg.sv
package updown_counter_pkg;

  localparam logic [3:0] COUNT_RESET  = 4'h0;
  localparam logic [3:0] DECADE_LIMIT = 4'h9;
  localparam logic [3:0] BINARY_LIMIT = 4'hf;
  localparam logic [3:0] COUNT_ZERO   = 4'h0;
  localparam int         SYNC_STAGES  = 3;

endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ns

// Three-stage input synchroniser; output changes once stages two and three agree
module pin_sync
  import updown_counter_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      pin_out
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic                   level;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  always_comb begin
    state_d       = state_q;
    state_d.stage = {state_q.stage[SYNC_STAGES-2:0], pin_in};
    if (state_q.stage[1] == state_q.stage[2]) begin
      state_d.level = state_q.stage[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= {{SYNC_STAGES{RESET_LEVEL}}, RESET_LEVEL};
    end else begin
      state_q <= state_d;
    end
  end

  assign pin_out = state_q.level;

endmodule

// File: hdl/dual_clock_updown_counter.sv
`timescale 1ns/1ns

module dual_clock_updown_counter
  import updown_counter_pkg::*;
#(
  parameter bit DECADE = 1'b1
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       count_up_clock,
  input  wire logic       count_down_clock,
  input  wire logic       preset_load_n,
  input  wire logic       clear_override,
  input  wire logic [3:0] preset_inputs,
  output logic      [3:0] count_outputs,
  output logic            up_terminal_out,
  output logic            down_terminal_out
);

  // -----------------------------------------------------------------
  // Types and state
  // -----------------------------------------------------------------
  // Operation taken at the coming edge
  typedef enum {
    OP_HOLD,
    OP_UP,
    OP_DOWN,
    OP_LOAD,
    OP_CLEAR
  } count_op_t;

  typedef struct packed {
    logic [3:0] count;
    logic       up_prev;
    logic       down_prev;
    logic       up_term;
    logic       down_term;
  } counter_state_t;

  counter_state_t state_q;
  counter_state_t state_d;

  logic       up_s;
  logic       down_s;
  logic       load_n_s;
  logic       clear_s;
  logic [3:0] preset_s;
  logic [3:0] limit;
  logic [3:0] next_count;
  logic       up_rise;
  logic       down_rise;
  count_op_t  op;

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  // Sample async pins
  pin_sync #(.RESET_LEVEL(1'b1)) up_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (count_up_clock),
    .pin_out (up_s)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) down_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (count_down_clock),
    .pin_out (down_s)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) load_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (preset_load_n),
    .pin_out (load_n_s)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) clear_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (clear_override),
    .pin_out (clear_s)
  );

  // Preset data takes the same path as the load strobe
  for (genvar bit_idx = 0; bit_idx < 4; bit_idx++) begin : g_preset
    pin_sync #(.RESET_LEVEL(1'b0)) preset_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin_in  (preset_inputs[bit_idx]),
      .pin_out (preset_s[bit_idx])
    );
  end

  // -----------------------------------------------------------------
  // Count arithmetic
  // -----------------------------------------------------------------
  // Modulus choice
  assign limit = DECADE ? DECADE_LIMIT : BINARY_LIMIT;

  function automatic logic [3:0] step(input logic [3:0] value, input logic up,
                                      input logic [3:0] top);
    logic [3:0] result;
    result = value;
    if (up) begin
      result = (value >= top) ? COUNT_ZERO : 4'(value + 4'h1);
    end else begin
      result = (value == COUNT_ZERO || value > top) ? top : 4'(value - 4'h1);
    end
    return result;
  endfunction

  // Rise of a synchronised clock against its previous level
  function automatic logic rising(input logic now_level, input logic prev_level);
    return now_level && !prev_level;
  endfunction

  // Terminal low at its count while its clock is low
  function automatic logic term_level(input logic [3:0] value, input logic [3:0] target,
                                      input logic clk_level);
    return !((value == target) && !clk_level);
  endfunction

  // One operation per edge: clear, then load, then a clock
  function automatic count_op_t pick_op(input logic clear, input logic load_n,
                                        input logic up_edge, input logic down_edge,
                                        input logic up_level, input logic down_level);
    count_op_t result;
    result = OP_HOLD;
    if (clear) begin
      result = OP_CLEAR;
    end else if (!load_n) begin
      result = OP_LOAD;
    end else if (up_edge && down_level) begin
      result = OP_UP;
    end else if (down_edge && up_level) begin
      result = OP_DOWN;
    end
    return result;
  endfunction

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  // Edges seen against the previous synchronised level
  assign up_rise   = rising(up_s, state_q.up_prev);
  assign down_rise = rising(down_s, state_q.down_prev);

  // A clock edge counts only while the other clock stands high
  assign op = pick_op(clear_s, load_n_s, up_rise, down_rise, up_s, down_s);

  // -----------------------------------------------------------------
  // Count register input
  // -----------------------------------------------------------------
  always_comb begin
    state_d           = state_q;
    next_count        = state_q.count;
    // Levels track during clear and load, so a later rise counts
    state_d.up_prev   = up_s;
    state_d.down_prev = down_s;
    case (op)
      // Neither a counting clock edge nor override
      OP_HOLD: begin
        next_count = state_q.count;
      end
      OP_UP: begin
        next_count = step(state_q.count, 1'b1, limit);
      end
      OP_DOWN: begin
        next_count = step(state_q.count, 1'b0, limit);
      end
      // Preset copied while load is low
      OP_LOAD: begin
        next_count = preset_s;
      end
      // Clear dominates load and both clocks
      OP_CLEAR: begin
        next_count = COUNT_RESET;
      end
      default: begin
        next_count = state_q.count;
      end
    endcase
    state_d.count     = next_count;
    // Up terminal follows up clock at limit
    state_d.up_term   = term_level(next_count, limit, up_s);
    // Down terminal follows down clock at zero
    state_d.down_term = term_level(next_count, COUNT_ZERO, down_s);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= {COUNT_RESET, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // Terminal outputs usable as next-stage clocks
  assign count_outputs     = state_q.count;
  assign up_terminal_out   = state_q.up_term;
  assign down_terminal_out = state_q.down_term;

endmodule

// File: verif/clock_driver.sv
`timescale 1ns/1ns
module clock_driver (
  input  wire logic sys_clk,
  output logic      count_up_clock,
  output logic      count_down_clock
);
  initial {count_up_clock, count_down_clock} = 2'h3;
  // One clock low at a time
  task automatic drop(input bit up, input int n);
    if (up) count_up_clock = 1'h0;
    else count_down_clock = 1'h0;
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic lift(input int n);
    {count_up_clock, count_down_clock} = 2'h3;
    repeat (n) @(negedge sys_clk);
  endtask
endmodule

// File: verif/counter_assertions.sv
`timescale 1ns/1ns
module counter_assertions
  import updown_counter_pkg::*;
#(parameter bit DECADE = 1'b1) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       count_up_clock,
  input wire logic       count_down_clock,
  input wire logic       preset_load_n,
  input wire logic       clear_override,
  input wire logic [3:0] preset_inputs,
  input wire logic [3:0] count_outputs,
  input wire logic       up_terminal_out,
  input wire logic       down_terminal_out
);
  localparam logic [3:0] LIM = DECADE ? DECADE_LIMIT : BINARY_LIMIT;
  wire logic idle = preset_load_n && !clear_override;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_clear_zero: assert property (clear_override [*6] |-> count_outputs == 4'h0)
    else $error("clear");
  a_load_copy: assert property ((!preset_load_n && !clear_override) [*6] |->
    count_outputs == preset_inputs) else $error("load");
  a_up_moves: assert property ($rose(count_up_clock) && count_down_clock && idle
    |-> ##[2:6] $changed(count_outputs)) else $error("up");
  a_down_moves: assert property ($rose(count_down_clock) && count_up_clock && idle
    |-> ##[2:6] $changed(count_outputs)) else $error("down");
  a_up_term_at: assert property (!up_terminal_out |-> count_outputs == LIM ||
    $past(count_outputs) == LIM) else $error("utc");
  a_dn_term_at: assert property (!down_terminal_out |-> count_outputs == 4'h0 ||
    $past(count_outputs) == 4'h0) else $error("dtc");
  a_up_term_low: assert property ((count_outputs == LIM && !count_up_clock && idle)
    [*6] |-> !up_terminal_out) else $error("utl");
  a_dn_term_low: assert property ((count_outputs == 4'h0 && !count_down_clock)
    [*6] |-> !down_terminal_out) else $error("dtl");
endmodule
bind dual_clock_updown_counter counter_assertions #(.DECADE(DECADE)) chk_i (.*);

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
  import updown_counter_pkg::*;
  localparam logic [3:0] LIM = DECADE_LIMIT;
  localparam logic [3:0] BLIM = BINARY_LIMIT;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, preset_load_n = 1'h1, clear_override = 1'h0;
  logic [3:0]  preset_inputs = 4'h0, count_outputs, exp = 4'h0;
  logic        count_up_clock, count_down_clock, up_terminal_out, down_terminal_out;
  logic [3:0]  bin_count, exp_b = 4'h0;
  logic        bin_up_term, bin_down_term;
  logic [15:0] lfsr = 16'h3a68;
  int          num_errors = 0, tests_run = 0;
  clock_driver clock_driver_i (.*);
  dual_clock_updown_counter dual_clock_updown_counter_i (.*);
  // Binary modulus copy on the same pins
  dual_clock_updown_counter #(.DECADE(1'b0)) dual_clock_updown_counter_bin_i (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .count_up_clock    (count_up_clock),
    .count_down_clock  (count_down_clock),
    .preset_load_n     (preset_load_n),
    .clear_override    (clear_override),
    .preset_inputs     (preset_inputs),
    .count_outputs     (bin_count),
    .up_terminal_out   (bin_up_term),
    .down_terminal_out (bin_down_term)
  );
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [3:0] step(input logic [3:0] c, input bit up,
                                      input logic [3:0] lim);
    if (up) return (c >= lim) ? 4'h0 : c + 4'h1;
    return (c == 4'h0 || c > lim) ? lim : c - 4'h1;
  endfunction
  task automatic check(input string what, input logic [3:0] e, input logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic ld(input logic [3:0] v);
    preset_inputs = v;
    preset_load_n = 1'h0;
    repeat (8) @(negedge sys_clk);
    check("count", clear_override ? 4'h0 : v, count_outputs);
    check("bin_count", clear_override ? 4'h0 : v, bin_count);
    clear_override = 1'h0;
    repeat (8) @(negedge sys_clk);
    exp = v;
    exp_b = v;
    check("count", exp, count_outputs);
    check("bin_count", exp_b, bin_count);
    preset_load_n = 1'h1;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic op(input bit up, input int n);
    clock_driver_i.drop(up, n);
    check("up_term", {3'h0, !(up && exp == LIM)}, {3'h0, up_terminal_out});
    check("dn_term", {3'h0, !(!up && exp == 4'h0)}, {3'h0, down_terminal_out});
    check("bin_up_term", {3'h0, !(up && exp_b == BLIM)}, {3'h0, bin_up_term});
    check("bin_dn_term", {3'h0, !(!up && exp_b == 4'h0)}, {3'h0, bin_down_term});
    clock_driver_i.lift(n);
    check("up_terms", 4'h3, {2'h0, up_terminal_out, bin_up_term});
    check("dn_terms", 4'h3, {2'h0, down_terminal_out, bin_down_term});
    exp = step(exp, up, LIM);
    exp_b = step(exp_b, up, BLIM);
    check("count", exp, count_outputs);
    check("bin_count", exp_b, bin_count);
  endtask
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    logic [15:0] r;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'h0;
    repeat (8) @(negedge sys_clk);
    check("count", exp, count_outputs);
    check("bin_count", exp_b, bin_count);
    clear_override = 1'h1;
    ld(4'h6);
    ld(LIM);
    op(1'h1, 5);
    ld(4'hf);
    op(1'h1, 5);
    ld(4'h0);
    op(1'h0, 5);
    clock_driver_i.drop(1'h1, 5);
    clear_override = 1'h1;
    ld(4'h3);
    clock_driver_i.lift(8);
    exp = step(exp, 1'h1, LIM);
    exp_b = step(exp_b, 1'h1, BLIM);
    check("count", exp, count_outputs);
    check("bin_count", exp_b, bin_count);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      if (r[15:14] == 2'h0)
        ld(r[3:0]);
      op(r[13], 5 + int'(r[2:0]));
    end
    results();
  end
endmodule
